/* core/host_wake_unit.sv */
/*
  Host wake unit slice: wake event routing to the unit interrupt channel,
  core control status one, base address registers, software event
  clear mode and a read-clear interrupt status with mask.
  Assumes reset pulses other than rst_i come from logic on clk_i,
  and that the LPC reset and supply detector are asynchronous pins.
*/
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
module host_wake_unit (
  // Clock and standby power-up reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Further reset sources, same clock domain
  input  wire logic        vcc_por_i,
  input  wire logic        warm_rst_i,
  input  wire logic        host_sw_rst_i,
  input  wire logic        watchdog_rst_i,
  input  wire logic        debug_rst_i,
  // Avalon-MM slave
  input  wire logic [17:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Wake event pulses from the detector
  input  wire logic        ring_indicate_one_i,
  input  wire logic        ring_indicate_two_i,
  input  wire logic        ring_event_i,
  // Asynchronous pins
  input  wire logic        lpc_reset_input_n_i,
  input  wire logic        host_power_detect_i,
  input  wire logic        lpc_activity_i,
  // Host side outputs
  output logic             host_keyboard_reset_out_n_o,
  output logic             cfg_access_en_o,
  output logic [15:0]      cfg_base_o,
  output logic             wake_irq_o,
  output logic             irq_o
);

  // Bus handshake state
  logic        ack_ff;          // High in the answer cycle
  logic [31:0] rdata_ff;        // Captured read word

  // Pin synchronisers
  logic        lpc_n_s1_ff;
  logic        lpc_n_s2_ff;
  logic        pwr_s1_ff;
  logic        pwr_s2_ff;

  // Register state
  logic [7:0]  route_ff;        // Wake routing enables
  logic [7:0]  wake_sts_ff;     // Latched wake events
  logic        hrst_ff;         // Host reset-out bit
  logic        valid_ff;        // Config address valid
  logic        lock_ff;         // Config address lock
  logic        mode_ff;         // Software event clear mode
  logic        early_ff;        // Reset host on early access
  logic [7:0]  base_low_ff;
  logic [7:0]  base_high_ff;
  logic        hevt_ff;         // Host event status bit 6
  logic        act_seen_ff;     // LPC activity during power-up
  logic        host_keyboard_reset_out_n_ff;
  logic        wake_irq_ff;
  logic        lpc_act_d_ff;    // Previous LPC reset level

  // Interrupt status and mask
  logic [host_wake_pkg::IRQ_W-1:0] irq_sts_ff;
  logic [host_wake_pkg::IRQ_W-1:0] irq_mask_ff;

  // Word address match against a register index
  function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  // Request decode
  wire         req      = avs_read_i | avs_write_i;
  wire         take     = req & ack_ff;
  wire         wr       = take & avs_write_i & avs_byteenable_i[0];
  wire         rd_take  = take & avs_read_i;
  wire  [7:0]  wd       = avs_writedata_i[7:0];
  wire         a_route  = hit(avs_address_i, host_wake_pkg::IDX_ROUTE);
  wire         a_wsts   = hit(avs_address_i, host_wake_pkg::IDX_WAKE_STS);
  wire         a_ctl1   = hit(avs_address_i, host_wake_pkg::IDX_CTL1);
  wire         a_ctl1s  = hit(avs_address_i, host_wake_pkg::IDX_CTL1_SET);
  wire         a_ctl3   = hit(avs_address_i, host_wake_pkg::IDX_CTL3);
  wire         a_blow   = hit(avs_address_i, host_wake_pkg::IDX_BASE_LOW);
  wire         a_bhigh  = hit(avs_address_i, host_wake_pkg::IDX_BASE_HIGH);
  wire         a_hevt   = hit(avs_address_i, host_wake_pkg::IDX_HOST_EVT);
  wire         a_ists   = hit(avs_address_i, host_wake_pkg::IDX_IRQ_STS);
  wire         a_imask  = hit(avs_address_i, host_wake_pkg::IDX_IRQ_MASK);

  // Synchronised pin levels
  wire         lpc_rst_act = ~lpc_n_s2_ff;             // [R7]
  wire         host_pwr    = pwr_s2_ff;                // [R6]

  // Write strobes, lock gates the protected fields
  wire         w_ctl1   = wr & a_ctl1;
  wire         w_blow   = wr & a_blow & ~lock_ff;      // [R12]
  wire         w_bhigh  = wr & a_bhigh & ~lock_ff;     // [R12]
  wire         w_early  = wr & a_ctl3 & ~lock_ff;      // [R16]
  wire         w_wsts   = wr & a_wsts;
  wire         w_hevt   = wr & a_hevt;

  // Software event bit next value
  wire         sw_cur   = wake_sts_ff[host_wake_pkg::BIT_SWEV];
  wire         sw_wr1   = w_wsts & wd[host_wake_pkg::BIT_SWEV];
  wire         hevt_wr1 = w_hevt & wd[host_wake_pkg::BIT_SWEV];
  // Mode 0 toggles on a one, mode 1 sets on a one
  wire         sw_host  = mode_ff ? (sw_cur | sw_wr1) : (sw_cur ^ sw_wr1); // [R14]
  // Mode 1 lets a host event clear take the software bit too
  wire         nxt_sw   = (mode_ff & hevt_wr1) ? 1'b0 : sw_host;           // [R15]
  wire         sw_rise  = ~sw_cur & nxt_sw;                                 // [R14]

  // Hardware wake events, set wins over a write-one clear
  wire  [7:0]  evt_set  = {1'b0, 3'b000, ring_event_i, 1'b0,
                           ring_indicate_two_i, ring_indicate_one_i};
  wire  [7:0]  evt_clr  = w_wsts ? (wd & ~(8'h01 << host_wake_pkg::BIT_SWEV)) : 8'h00;
  wire  [7:0]  evt_hw   = (wake_sts_ff & ~evt_clr) | evt_set;
  wire  [7:0]  nxt_wsts = ((evt_hw & ~(8'h01 << host_wake_pkg::BIT_SWEV))
                          | ({7'h00, nxt_sw} << host_wake_pkg::BIT_SWEV))
                          & host_wake_pkg::ROUTE_MASK;                      // [R18]

  // Host event status, rise of software bit wins over clear
  wire         nxt_hevt = sw_rise | (hevt_ff & ~hevt_wr1);                 // [R14] [R15]

  // Routed wake request, independent of any general wake enable
  wire         nxt_wirq = |(wake_sts_ff & route_ff);                        // [R2] [R17]

  // Valid bit: set by high write, write-one clear unless locked
  wire         v_clr    = w_ctl1 & wd[host_wake_pkg::BIT_VALID] & ~lock_ff; // [R9] [R12]
  wire         nxt_vld  = w_bhigh | (valid_ff & ~v_clr);                    // [R8]

  // Clear mode: set through the set register, write-one clears
  wire         m_set    = wr & a_ctl1s & wd[host_wake_pkg::BIT_MODE];
  wire         m_clr    = w_ctl1 & wd[host_wake_pkg::BIT_MODE];              // [R13]
  wire         nxt_mode = (mode_ff & ~m_clr & ~lpc_rst_act) | (m_set & ~lpc_rst_act); // [R13]

  // Interrupt events and read-clear of captured bits only
  wire  [host_wake_pkg::IRQ_W-1:0] irq_evt = {
    lpc_rst_act & ~lpc_act_d_ff,
    w_bhigh & ~valid_ff,
    sw_rise,
    |(evt_set & route_ff)};
  wire  [host_wake_pkg::IRQ_W-1:0] irq_rclr =
    (rd_take & a_ists) ? rdata_ff[host_wake_pkg::IRQ_W-1:0] : '0;
  wire  [host_wake_pkg::IRQ_W-1:0] nxt_ists = (irq_sts_ff & ~irq_rclr) | irq_evt;

  // Core control status one read view, bits 7 and 6 read zero
  wire  [7:0]  ctl1_rd  = {2'b00, mode_ff, lock_ff, valid_ff,
                           lpc_rst_act, host_pwr, hrst_ff};                  // [R18]

  // Read multiplexer, unmapped words read zero
  wire  [7:0]  rmux =
    a_route ? route_ff :
    a_wsts  ? wake_sts_ff :
    a_ctl1  ? ctl1_rd :
    a_ctl3  ? {7'h00, early_ff} :
    a_blow  ? base_low_ff :
    a_bhigh ? base_high_ff :
    a_hevt  ? {1'b0, hevt_ff, 6'h00} :
    a_ists  ? {{(8-host_wake_pkg::IRQ_W){1'b0}}, irq_sts_ff} :
    a_imask ? {{(8-host_wake_pkg::IRQ_W){1'b0}}, irq_mask_ff} :
              8'h00;

  // Keyboard reset: firmware force or early LPC access
  wire         nxt_host_keyboard_reset_out_n = ~(hrst_ff | (early_ff & vcc_por_i & act_seen_ff)); // [R5]

  // One wait cycle, then the answer
  assign avs_waitrequest_o = req & ~ack_ff;
  assign avs_readdata_o    = rdata_ff;

  // Handshake and read capture
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= req & ~ack_ff;
      rdata_ff <= (avs_read_i & ~ack_ff) ? {24'h00_0000, rmux} : rdata_ff;
    end
  end

  // Two-flop synchronisers for the asynchronous pins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lpc_n_s1_ff <= 1'b1;
      lpc_n_s2_ff <= 1'b1;
      pwr_s1_ff   <= 1'b0;
      pwr_s2_ff   <= 1'b0;
    end else begin
      lpc_n_s1_ff <= lpc_reset_input_n_i;
      lpc_n_s2_ff <= lpc_n_s1_ff;
      pwr_s1_ff   <= host_power_detect_i;
      pwr_s2_ff   <= pwr_s1_ff;
    end
  end

  // Routing enables, cleared on host-domain software reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      route_ff <= host_wake_pkg::ROUTE_RST;                   // [R1]
    end else if (host_sw_rst_i) begin
      route_ff <= host_wake_pkg::ROUTE_RST;                   // [R1]
    end else if (wr & a_route) begin
      route_ff <= wd & host_wake_pkg::ROUTE_MASK;             // [R3] [R18]
    end
  end

  // Wake status and host event status
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_sts_ff <= 8'h00;
      hevt_ff     <= 1'b0;
      wake_irq_ff <= 1'b0;
    end else begin
      wake_sts_ff <= nxt_wsts;
      hevt_ff     <= nxt_hevt;
      wake_irq_ff <= nxt_wirq;
    end
  end

  // Reset-out bit, the only bit warm reset touches
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hrst_ff <= 1'b0;
    end else if (vcc_por_i | warm_rst_i) begin
      hrst_ff <= 1'b0;                                        // [R4]
    end else if (w_ctl1) begin
      hrst_ff <= wd[host_wake_pkg::BIT_HRST];
    end
  end

  // Valid follows main power-up only; clear mode also clears on LPC reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_ff <= 1'b0;
      mode_ff  <= 1'b0;
    end else if (vcc_por_i) begin
      valid_ff <= 1'b0;                                       // [R4]
      mode_ff  <= 1'b0;                                       // [R13]
    end else begin
      valid_ff <= nxt_vld;
      mode_ff  <= nxt_mode;
    end
  end

  // Lock survives warm and host resets on purpose
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_ff <= 1'b0;
    end else if (vcc_por_i | watchdog_rst_i | debug_rst_i) begin
      lock_ff <= 1'b0;                                        // [R11]
    end else if (w_ctl1 & wd[host_wake_pkg::BIT_LOCK]) begin
      lock_ff <= 1'b1;                                        // [R12]
    end
  end

  // Base address bytes, main power-up only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_low_ff  <= 8'h00;
      base_high_ff <= 8'h00;
    end else if (vcc_por_i) begin
      base_low_ff  <= 8'h00;
      base_high_ff <= 8'h00;
    end else begin
      base_low_ff  <= w_blow ? wd : base_low_ff;
      base_high_ff <= w_bhigh ? wd : base_high_ff;
    end
  end

  // Early-access setting kept on standby supply
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      early_ff <= host_wake_pkg::EARLY_RST;
    end else if (w_early) begin
      early_ff <= wd[host_wake_pkg::BIT_EARLY];
    end
  end

  // Remember LPC activity while power-up reset runs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_seen_ff <= 1'b0;
      host_keyboard_reset_out_n_ff  <= 1'b1;
    end else begin
      act_seen_ff <= vcc_por_i & (act_seen_ff | lpc_activity_i);
      host_keyboard_reset_out_n_ff  <= nxt_host_keyboard_reset_out_n;
    end
  end

  // Interrupt status, mask and edge history
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_sts_ff   <= '0;
      irq_mask_ff  <= '0;
      lpc_act_d_ff <= 1'b0;
    end else begin
      irq_sts_ff   <= nxt_ists;
      irq_mask_ff  <= (wr & a_imask) ? wd[host_wake_pkg::IRQ_W-1:0] : irq_mask_ff;
      lpc_act_d_ff <= lpc_rst_act;
    end
  end

  // Outputs, all from flip-flops except the handshake and the masked irq_o
  assign host_keyboard_reset_out_n_o = host_keyboard_reset_out_n_ff;            // [R5]
  assign cfg_access_en_o = valid_ff;                          // [R10]
  assign cfg_base_o      = {base_high_ff, base_low_ff};       // [R10]
  assign wake_irq_o      = wake_irq_ff;                       // [R17]
  assign irq_o           = |(irq_sts_ff & irq_mask_ff);

endmodule : host_wake_unit

/* include/host_wake_pkg.sv */
/*
  Constants for the host wake unit slice: register indices, field
  positions, reset values and interrupt bit layout.
  Assumes a 32-bit Avalon-MM slave in which every register takes one word.
  The byte address of a register is four times its index.
*/
// Operation
// R1: Routing register clears on standby power-up, host reset
// R2: Routed wake events raise interrupt, ignoring wake enable
// R3: Route bits 0,1,3,6; others reserved, default off
// R4: Bit 0 warm reset; rest main power-up
// R5: Reset-out bit drives keyboard reset low
// R6: Host power flag mirrors supply detector
// R7: LPC reset flag reads one while input low
// R8: Writing base high sets address valid
// R9: Writing one clears valid; zero ignored
// R10: Valid low disables host config access
// R11: Lock clears on power-up, watchdog, debugger only
// R12: Lock is write-one-set, freezes valid and bases
// R13: Clear mode cleared by power-up, LPC reset, write-one
// R14: Mode 0: host write toggles; rise sets event
// R15: Mode 1: event write clears both bits
// R16: Lock blocks early-access reset setting writes
// R17: Interrupt is OR of routed status bits
// R18: Reserved bits read zero, ignore writes
package host_wake_pkg;

  // Register indices, byte address is index times four
  localparam logic [15:0] IDX_ROUTE     = 16'h0015;
  localparam logic [15:0] IDX_WAKE_STS  = 16'h0010;
  localparam logic [15:0] IDX_CTL1      = 16'hfcc0;
  localparam logic [15:0] IDX_CTL1_SET  = 16'hfcc1;
  localparam logic [15:0] IDX_CTL3      = 16'hfcc4;
  localparam logic [15:0] IDX_BASE_LOW  = 16'hfcc6;
  localparam logic [15:0] IDX_BASE_HIGH = 16'hfcc8;
  localparam logic [15:0] IDX_HOST_EVT  = 16'hfcca;
  localparam logic [15:0] IDX_IRQ_STS   = 16'hfcd0;
  localparam logic [15:0] IDX_IRQ_MASK  = 16'hfcd2;

  // Routing and wake status field positions
  localparam int BIT_RI1    = 0;
  localparam int BIT_RI2    = 1;
  localparam int BIT_RING   = 3;
  localparam int BIT_SWEV   = 6;
  localparam logic [7:0] ROUTE_MASK = 8'h4b;
  localparam logic [7:0] ROUTE_RST  = 8'h00;

  // Core control status one field positions
  localparam int BIT_HRST   = 0;
  localparam int BIT_HPWR   = 1;
  localparam int BIT_LPCRST = 2;
  localparam int BIT_VALID  = 3;
  localparam int BIT_LOCK   = 4;
  localparam int BIT_MODE   = 5;

  // Third control register, early-access host reset
  localparam int BIT_EARLY  = 0;
  localparam logic EARLY_RST = 1'b1;

  // Interrupt status bits
  localparam int IRQ_W      = 4;
  localparam int IRQ_WAKE   = 0;
  localparam int IRQ_HEVT   = 1;
  localparam int IRQ_VALID  = 2;
  localparam int IRQ_LPCRST = 3;

endpackage : host_wake_pkg

/* sim/host_side_model.sv */
/*
  Behavioural host chipset beside the host wake unit: supply detector,
  LPC reset and LPC activity.
  Assumes the bench commands the supply and the unit drives keyboard reset.
*/
`timescale 1ns/100ps
module host_side_model (
  // Clock, reset and bench command
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic power_good_i,
  // Unit pins
  input  wire logic host_keyboard_reset_out_n_i,
  output logic      lpc_reset_n_o,
  output logic      power_detect_o,
  output logic      activity_o
);
  logic [1:0] hold_ff;  // LPC reset hold after the cause goes away
  logic [3:0] act_ff;   // Spacing of LPC cycles

  // A real chipset keeps LPC reset a while after keyboard reset or supply loss
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_ff <= 2'h3;
      act_ff  <= 4'h0;
    end else begin
      if (!host_keyboard_reset_out_n_i || !power_good_i) hold_ff <= 2'h3;
      else if (hold_ff != 2'h0) hold_ff <= hold_ff - 2'h1;
      act_ff <= act_ff + 4'h1;
    end
  end

  // LPC pins change only from flops and the supply pin follows the bench command, so the unit sees clean levels
  assign lpc_reset_n_o  = (hold_ff == 2'h0);
  assign power_detect_o = power_good_i;
  // No LPC cycles while the bus is held in reset
  assign activity_o     = (act_ff == 4'hf) && lpc_reset_n_o;
endmodule : host_side_model

/* sim/host_wake_irq_and_control_status_test.sv */
/*
  Self-checking bench for the host wake unit: register rows first,
  then pins, lock, reset, interrupt and software event cases.
  Assumes the host side model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
module host_wake_irq_and_control_status_test;
  typedef struct packed {logic [15:0] idx; logic [7:0] wd; logic [7:0] ex;} row_t;
  logic        clk_i, rst_i, pwr, rd, wr, wq, kb_n, cfg_en, wirq, irq, lpc_n, hpd, act;
  logic [7:0]  sig;  // Pulses: ring, ri2, ri1, debug, watchdog, host sw, warm, main power-up
  logic [3:0]  be;
  logic [17:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [15:0] base;
  int          err_total, n_compared;
  // Written value beside the value read back; the last row is unmapped
  row_t rows [5] = '{'{host_wake_pkg::IDX_ROUTE, 8'hff, 8'h4b}, '{host_wake_pkg::IDX_ROUTE, 8'h00, 8'h00},
                     '{host_wake_pkg::IDX_BASE_LOW, 8'h12, 8'h12}, '{host_wake_pkg::IDX_BASE_HIGH, 8'h34, 8'h34},
                     '{16'h0020, 8'hff, 8'h00}};

  host_wake_unit u_host_wake_unit (.clk_i, .rst_i, .vcc_por_i(sig[0]), .warm_rst_i(sig[1]),
    .host_sw_rst_i(sig[2]), .watchdog_rst_i(sig[3]), .debug_rst_i(sig[4]), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .ring_indicate_one_i(sig[5]), .ring_indicate_two_i(sig[6]), .ring_event_i(sig[7]),
    .lpc_reset_input_n_i(lpc_n), .host_power_detect_i(hpd), .lpc_activity_i(act),
    .host_keyboard_reset_out_n_o(kb_n), .cfg_access_en_o(cfg_en), .cfg_base_o(base), .wake_irq_o(wirq),
    .irq_o(irq));
  host_side_model u_host_side_model (.clk_i, .rst_i, .power_good_i(pwr), .host_keyboard_reset_out_n_i(kb_n),
    .lpc_reset_n_o(lpc_n), .power_detect_o(hpd), .activity_o(act));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic results;
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge; data taken and request dropped there
  task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    adr  <= {i, 2'b00};
    wdat <= {24'h00_0000, d};
    wr   <= w;
    rd   <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wq === 1'b0) break;
    end
    if (n == 20) begin
      err_total++;
      results();
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rdc(input logic [15:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(q, {24'h00_0000, e});
  endtask : rdc

  task automatic pulse(input int b);
    @(posedge clk_i);
    sig[b] <= 1'b1;
    @(posedge clk_i);
    sig[b] <= 1'b0;
  endtask : pulse

  initial begin
    rst_i = 1'b1;
    pwr = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    sig = 8'h00;
    be = 4'h1;
    adr = 18'h0_0000;
    wdat = 32'h0000_0000;
    err_total = 0;
    n_compared = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rdc(host_wake_pkg::IDX_ROUTE, 8'h00);
    rdc(host_wake_pkg::IDX_CTL1, 8'h02);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].ex);
    end
    chk(32'(cfg_en), 32'h1);
    chk(32'(base), 32'h3412);
    bus(1'b1, host_wake_pkg::IDX_CTL1, 8'h00);
    rdc(host_wake_pkg::IDX_CTL1, 8'h0a);
    bus(1'b1, host_wake_pkg::IDX_CTL1, 8'h08);
    rdc(host_wake_pkg::IDX_CTL1, 8'h02);
    chk(32'(cfg_en), 32'h0);
    // Supply loss also holds LPC reset at the model
    pwr <= 1'b0;
    repeat (8) @(posedge clk_i);
    rdc(host_wake_pkg::IDX_CTL1, 8'h04);
    pwr <= 1'b1;
    repeat (10) @(posedge clk_i);
    bus(1'b1, host_wake_pkg::IDX_BASE_HIGH, 8'h34);
    bus(1'b1, host_wake_pkg::IDX_CTL1, 8'h11);
    repeat (6) @(posedge clk_i);
    chk(32'(kb_n), 32'h0);
    rdc(host_wake_pkg::IDX_CTL1, 8'h1f);
    // Locked: valid clear, base and early-access writes all bounce
    bus(1'b1, host_wake_pkg::IDX_CTL1, 8'h19);
    bus(1'b1, host_wake_pkg::IDX_BASE_HIGH, 8'h55);
    bus(1'b1, host_wake_pkg::IDX_CTL3, 8'h00);
    rdc(host_wake_pkg::IDX_CTL1, 8'h1f);
    rdc(host_wake_pkg::IDX_BASE_HIGH, 8'h34);
    rdc(host_wake_pkg::IDX_CTL3, 8'h01);
    pulse(1);
    repeat (12) @(posedge clk_i);
    rdc(host_wake_pkg::IDX_CTL1, 8'h1a);
    chk(32'(kb_n), 32'h1);
    for (int b = 3; b < 5; b++) begin
      bus(1'b1, host_wake_pkg::IDX_CTL1, 8'h10);
      pulse(b);
      rdc(host_wake_pkg::IDX_CTL1, 8'h0a);
    end
    // Only the ring event is routed
    bus(1'b1, host_wake_pkg::IDX_ROUTE, 8'h08);
    bus(1'b1, host_wake_pkg::IDX_IRQ_MASK, 8'h01);
    pulse(5);
    repeat (3) @(posedge clk_i);
    chk(32'(wirq), 32'h0);
    pulse(7);
    repeat (3) @(posedge clk_i);
    chk(32'(wirq), 32'h1);
    chk(32'(irq), 32'h1);
    bus(1'b1, host_wake_pkg::IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    bus(1'b1, host_wake_pkg::IDX_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h1);
    bus(1'b0, host_wake_pkg::IDX_IRQ_STS, 8'h00);
    chk(32'(q[0]), 32'h1);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    bus(1'b1, host_wake_pkg::IDX_WAKE_STS, 8'h08);
    repeat (3) @(posedge clk_i);
    chk(32'(wirq), 32'h0);
    pulse(7);
    pulse(2);
    repeat (3) @(posedge clk_i);
    chk(32'(wirq), 32'h0);
    rdc(host_wake_pkg::IDX_ROUTE, 8'h00);
    bus(1'b1, host_wake_pkg::IDX_WAKE_STS, 8'h0b);
    // Clear mode 0: host writes toggle the software event; mode 1: host writes set it
    bus(1'b1, host_wake_pkg::IDX_WAKE_STS, 8'h40);
    rdc(host_wake_pkg::IDX_WAKE_STS, 8'h40);
    rdc(host_wake_pkg::IDX_HOST_EVT, 8'h40);
    bus(1'b1, host_wake_pkg::IDX_WAKE_STS, 8'h40);
    rdc(host_wake_pkg::IDX_WAKE_STS, 8'h00);
    bus(1'b1, host_wake_pkg::IDX_HOST_EVT, 8'h40);
    bus(1'b1, host_wake_pkg::IDX_CTL1_SET, 8'h20);
    rdc(host_wake_pkg::IDX_CTL1, 8'h2a);
    bus(1'b1, host_wake_pkg::IDX_WAKE_STS, 8'h40);
    bus(1'b1, host_wake_pkg::IDX_HOST_EVT, 8'h40);
    rdc(host_wake_pkg::IDX_WAKE_STS, 8'h00);
    rdc(host_wake_pkg::IDX_HOST_EVT, 8'h00);
    bus(1'b1, host_wake_pkg::IDX_CTL1, 8'h20);
    rdc(host_wake_pkg::IDX_CTL1, 8'h0a);
    bus(1'b1, host_wake_pkg::IDX_CTL1_SET, 8'h20);
    pwr <= 1'b0;
    repeat (8) @(posedge clk_i);
    pwr <= 1'b1;
    repeat (10) @(posedge clk_i);
    rdc(host_wake_pkg::IDX_CTL1, 8'h0a);
    pulse(0);
    repeat (3) @(posedge clk_i);
    chk(32'(cfg_en), 32'h0);
    chk(32'(base), 32'h0);
    // Host cycles during a long main power-up reset pull keyboard reset
    sig[0] <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk(32'(kb_n), 32'h0);
    sig[0] <= 1'b0;
    results();
  end
endmodule : host_wake_irq_and_control_status_test

/* sim/host_wake_properties.sv */
/*
  Concurrent checks on the host wake unit ports.
  Assumes one clock clk_i with rst_i as the asynchronous reset.
*/
`timescale 1ns/100ps
module host_wake_checks (
  // Clock and resets
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        vcc_por_i,
  input wire logic        host_sw_rst_i,
  // Register bus
  input wire logic [17:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Pins and outputs
  input wire logic        ring_indicate_one_i,
  input wire logic        ring_indicate_two_i,
  input wire logic        ring_event_i,
  input wire logic        lpc_reset_input_n_i,
  input wire logic        host_power_detect_i,
  input wire logic        host_keyboard_reset_out_n_o,
  input wire logic        cfg_access_en_o,
  input wire logic        wake_irq_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Decoded bus events; done marks the edge at which the access lands
  wire        req     = avs_read_i | avs_write_i;
  wire        done    = req & ~avs_waitrequest_o;
  wire [15:0] idx     = avs_address_i[17:2];
  wire        wr_ok   = done & avs_write_i & avs_byteenable_i[0];
  wire        wr_ctl  = wr_ok & (idx == host_wake_pkg::IDX_CTL1);
  wire        wr_high = wr_ok & (idx == host_wake_pkg::IDX_BASE_HIGH);
  wire        rd_ctl  = done & avs_read_i & (idx == host_wake_pkg::IDX_CTL1);
  wire        wake_in = ring_indicate_one_i | ring_indicate_two_i | ring_event_i | wr_ok;
  logic [1:0] pins_ff;    // Last pin levels
  logic [3:0] stable_ff;  // Cycles the pins held still

  // Flags lag the pins through synchronisers, so only settled pins are judged
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_ff   <= 2'h0;
      stable_ff <= 4'h0;
    end else begin
      pins_ff <= {lpc_reset_input_n_i, host_power_detect_i};
      if (pins_ff != {lpc_reset_input_n_i, host_power_detect_i}) stable_ff <= 4'h0;
      else if (stable_ff != 4'hf) stable_ff <= stable_ff + 4'h1;
    end
  end

  sequence s_set_hrst;
    wr_ctl && avs_writedata_i[host_wake_pkg::BIT_HRST];
  endsequence
  sequence s_settled_ctl;
    rd_ctl && (stable_ff > 4'h5);
  endsequence

  a_wait_single: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held longer than one cycle");
  a_wait_idle: assert property (!req |-> !avs_waitrequest_o)
    else $error("waitrequest without a request");
  a_read_upper: assert property (done && avs_read_i |-> avs_readdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_host_keyboard_reset_out_follow: assert property (s_set_hrst |-> ##[1:3] !host_keyboard_reset_out_n_o)
    else $error("keyboard reset not driven low");
  a_power_flag: assert property (s_settled_ctl |-> avs_readdata_o[host_wake_pkg::BIT_HPWR] == host_power_detect_i)
    else $error("host power flag wrong");
  a_lpc_flag: assert property (s_settled_ctl |-> avs_readdata_o[host_wake_pkg::BIT_LPCRST] == !lpc_reset_input_n_i)
    else $error("LPC reset flag wrong");
  a_valid_cause: assert property ($rose(cfg_access_en_o) |-> $past(wr_high) || $past(wr_high, 2))
    else $error("config access enabled without base high write");
  a_valid_drop: assert property ($fell(cfg_access_en_o) |-> $past(wr_ctl || vcc_por_i) || $past(wr_ctl || vcc_por_i, 2))
    else $error("config access dropped without cause");
  a_route_clear: assert property (host_sw_rst_i |-> ##2 !wake_irq_o)
    else $error("wake interrupt stays after host reset");
  a_wake_cause: assert property ($rose(wake_irq_o) |-> $past(wake_in) || $past(wake_in, 2) || $past(wake_in, 3))
    else $error("wake interrupt without event");
  a_mask_off: assert property (wr_ok && idx == host_wake_pkg::IDX_IRQ_MASK && avs_writedata_i[3:0] == 4'h0
                               |-> ##[1:3] !irq_o)
    else $error("interrupt stays with mask cleared");
endmodule : host_wake_checks

bind host_wake_unit host_wake_checks u_host_wake_checks (.clk_i, .rst_i, .vcc_por_i, .host_sw_rst_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
  .avs_waitrequest_o, .ring_indicate_one_i, .ring_indicate_two_i, .ring_event_i, .lpc_reset_input_n_i,
  .host_power_detect_i, .host_keyboard_reset_out_n_o, .cfg_access_en_o, .wake_irq_o, .irq_o);
